// ### logic/rsh_regs.vh
// constants for the remote serial handshake port
`ifndef RSH_REGS_VH
`define RSH_REGS_VH
`define RSH_CLK_HZ 32'h017D7840
`define RSH_BAUD_MIN 17'h02580
`define RSH_BAUD_MAX 17'h1C200
`define RSH_DATA_BITS 8
`define RSH_STOP_BITS 1
`define RSH_ANNOUNCE 8'hAA
`define RSH_GO_AHEAD 8'hCC
`define RSH_TERMINATOR 8'h0A
`define RSH_OVS 16
`define RSH_OVS_HALF 4'h7
`define RSH_OVS_LAST 4'hF
`define RSH_BIT_LAST 3'h7
`endif

// ### logic/rsh_baud_gen.v
// oversampling enable generator, OVS ticks per bit
`timescale 1ns/1ns
`include "rsh_regs.vh"
module rsh_baud_gen #(
    parameter CLK_HZ = `RSH_CLK_HZ,
    parameter OVS = `RSH_OVS
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // rate select, baud value in bits per second
    input wire [16:0] baud,
    // one-cycle enable at OVS times the bit rate
    output reg tick
);
    reg [15:0] cnt;
    wire [31:0] div_full;
    wire [15:0] div;
    // recomputed combinationally; the divide is constant-heavy but one-shot per setting
    assign div_full = CLK_HZ / ({15'h0000, baud} * OVS);
    assign div = (div_full[15:0] == 16'h0000) ? 16'h0001 : div_full[15:0];
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            cnt <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt >= div - 16'h0001)
        begin
            cnt <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // rsh_baud_gen

// ### logic/rsh_port.v
// remote serial handshake port: uart with announce/go-ahead command gating
// How it works
// - separate tx and rx lines, asynchronous characters, no link clock
// - baud selectable 9600 to 115200, host must match
// - frames carry 8 data bits, no parity, one stop bit
// - on announce while able to accept, send go-ahead byte
// - line feed byte ends the command
// - response bytes are sent straight away, no handshake
`timescale 1ns/1ns
`include "rsh_regs.vh"
module rsh_port #(
    parameter CLK_HZ = `RSH_CLK_HZ,
    parameter BAUD_DEFAULT = `RSH_BAUD_MIN
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // serial link
    input wire rxd,
    output reg txd,
    // configuration
    input wire [16:0] baud_sel,
    input wire cmd_ready,
    // received command characters
    output reg [7:0] cmd_data,
    output reg cmd_valid,
    output reg cmd_end,
    output reg hs_busy,
    output reg frame_err,
    // response characters
    input wire [7:0] rsp_data,
    input wire rsp_valid,
    output reg rsp_ready
);
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_STOP = 2'h3;
    localparam HS_WAIT = 1'b0;
    localparam HS_CMD = 1'b1;

    wire tick;
    wire [16:0] baud_clip;
    // out-of-range rates are pulled into the supported span
    assign baud_clip = (baud_sel < `RSH_BAUD_MIN) ? BAUD_DEFAULT[16:0] :
                       (baud_sel > `RSH_BAUD_MAX) ? `RSH_BAUD_MAX : baud_sel;

    rsh_baud_gen #(.CLK_HZ(CLK_HZ), .OVS(`RSH_OVS)) u_baud (
        .clk(clk),
        .nrst(nrst),
        .baud(baud_clip),
        .tick(tick)
    );

    // receiver, oversampled, sampling mid-bit
    reg [1:0] rx_st;
    reg [3:0] rx_ph;
    reg [2:0] rx_bit;
    reg [7:0] rx_sh;
    reg rx_done;
    reg [7:0] rx_byte;
    always @(posedge clk)
    begin
        rx_done <= 1'b0;
        if (!nrst)
        begin
            rx_st <= ST_IDLE;
            rx_ph <= 4'h0;
            rx_bit <= 3'h0;
            rx_sh <= 8'h00;
            rx_byte <= 8'h00;
            frame_err <= 1'b0;
        end
        else if (tick)
        begin
            case (rx_st)
                ST_IDLE:
                begin
                    rx_ph <= 4'h0;
                    if (!rxd)
                        rx_st <= ST_START;
                end
                ST_START:
                begin
                    rx_ph <= rx_ph + 4'h1;
                    if (rx_ph == `RSH_OVS_HALF)
                    begin
                        rx_ph <= 4'h0;
                        rx_bit <= 3'h0;
                        rx_st <= rxd ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    rx_ph <= rx_ph + 4'h1;
                    if (rx_ph == `RSH_OVS_LAST)
                    begin
                        rx_sh <= {rxd, rx_sh[7:1]};
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == `RSH_BIT_LAST)
                            rx_st <= ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    rx_ph <= rx_ph + 4'h1;
                    if (rx_ph == `RSH_OVS_LAST)
                    begin
                        rx_st <= ST_IDLE;
                        frame_err <= !rxd;
                        if (rxd)
                        begin
                            rx_done <= 1'b1;
                            rx_byte <= rx_sh;
                        end
                    end
                end
                default: rx_st <= ST_IDLE;
            endcase
        end
    end

    // handshake: only announce is honoured until go-ahead is queued
    reg hs_st;
    reg go_pend;
    reg go_sent;
    always @(posedge clk)
    begin
        cmd_valid <= 1'b0;
        cmd_end <= 1'b0;
        if (!nrst)
        begin
            hs_st <= HS_WAIT;
            go_pend <= 1'b0;
            cmd_data <= 8'h00;
            hs_busy <= 1'b0;
        end
        else
        begin
            if (go_sent)
                go_pend <= 1'b0;
            if (rx_done)
            begin
                case (hs_st)
                    HS_WAIT:
                    begin
                        // stray bytes before announce are dropped, host must wait
                        if (rx_byte == `RSH_ANNOUNCE && cmd_ready)
                        begin
                            go_pend <= 1'b1;
                            hs_st <= HS_CMD;
                        end
                    end
                    HS_CMD:
                    begin
                        cmd_data <= rx_byte;
                        cmd_valid <= 1'b1;
                        if (rx_byte == `RSH_TERMINATOR)
                        begin
                            cmd_end <= 1'b1;
                            hs_st <= HS_WAIT;
                        end
                    end
                    default: hs_st <= HS_WAIT;
                endcase
            end
            hs_busy <= (hs_st == HS_CMD);
        end
    end

    // transmitter; go-ahead takes priority over response data
    reg [1:0] tx_st;
    reg [3:0] tx_ph;
    reg [2:0] tx_bit;
    reg [7:0] tx_sh;
    always @(posedge clk)
    begin
        go_sent <= 1'b0;
        rsp_ready <= 1'b0;
        if (!nrst)
        begin
            tx_st <= ST_IDLE;
            tx_ph <= 4'h0;
            tx_bit <= 3'h0;
            tx_sh <= 8'h00;
            txd <= 1'b1;
        end
        else
        begin
            case (tx_st)
                ST_IDLE:
                begin
                    txd <= 1'b1;
                    tx_ph <= 4'h0;
                    if (go_pend && !go_sent)
                    begin
                        tx_sh <= `RSH_GO_AHEAD;
                        go_sent <= 1'b1;
                        tx_st <= ST_START;
                    end
                    else if (rsp_valid && !rsp_ready)
                    begin
                        // no handshake toward the host
                        tx_sh <= rsp_data;
                        rsp_ready <= 1'b1;
                        tx_st <= ST_START;
                    end
                end
                ST_START:
                begin
                    txd <= 1'b0;
                    if (tick)
                    begin
                        tx_ph <= tx_ph + 4'h1;
                        if (tx_ph == `RSH_OVS_LAST)
                        begin
                            tx_bit <= 3'h0;
                            tx_st <= ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    txd <= tx_sh[0];
                    if (tick)
                    begin
                        tx_ph <= tx_ph + 4'h1;
                        if (tx_ph == `RSH_OVS_LAST)
                        begin
                            tx_sh <= {1'b0, tx_sh[7:1]};
                            tx_bit <= tx_bit + 3'h1;
                            if (tx_bit == `RSH_BIT_LAST)
                                tx_st <= ST_STOP;
                        end
                    end
                end
                ST_STOP:
                begin
                    txd <= 1'b1;
                    if (tick)
                    begin
                        tx_ph <= tx_ph + 4'h1;
                        if (tx_ph == `RSH_OVS_LAST)
                            tx_st <= ST_IDLE;
                    end
                end
                default: tx_st <= ST_IDLE;
            endcase
        end
    end
endmodule // rsh_port

// ### tb/rsh_host.sv
// host computer model: sends and receives 8n1 characters on the serial link
`timescale 1ns/1ns
module rsh_host #(
    parameter BIT = 208
) (
    // clock
    input wire clk,
    // serial link
    output logic rxd,
    input wire txd
);
    initial rxd = 1'b1;
    // host drives the instrument rx line; stop may be forced low for a bad frame
    task send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        integer i;
        begin
            f = {stop, b, 1'b0};
            for (i = 0; i < 10; i++)
            begin
                @(posedge clk) rxd <= f[i];
                repeat (BIT - 1) @(posedge clk);
            end
            @(posedge clk) rxd <= 1'b1;
            repeat (BIT) @(posedge clk);
        end
    endtask
    // host is always able to receive, so it just waits for a start bit
    task recv(output logic [7:0] b, output logic ok);
        integer i;
        begin
            ok = 1'b0;
            b = 8'h00;
            for (i = 0; i < 3000 && txd !== 1'b0; i++)
                @(posedge clk);
            if (txd === 1'b0)
            begin
                repeat (BIT / 2) @(posedge clk);
                for (i = 0; i < 8; i++)
                begin
                    repeat (BIT) @(posedge clk);
                    b[i] = txd;
                end
                repeat (BIT) @(posedge clk);
                ok = (txd === 1'b1);
            end
        end
    endtask
endmodule // rsh_host

// ### tb/rsh_port_asserts.sv
// assertions on the ports of the serial handshake port
`timescale 1ns/1ns
module rsh_port_asserts (
    // clock and reset
    input wire clk,
    input wire nrst,
    // watched outputs
    input wire txd,
    input wire [7:0] cmd_data,
    input wire cmd_valid,
    input wire cmd_end,
    input wire hs_busy,
    input wire rsp_ready
);
    logic [11:0] gap;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // cycles since the last response hand-off, saturating
    always @(posedge clk)
    begin
        if (!nrst)
            gap <= 12'hFFF;
        else if (rsp_ready)
            gap <= 12'h000;
        else if (gap != 12'hFFF)
            gap <= gap + 12'h001;
    end
    // no response frame in flight, so the go-ahead cannot be held back
    sequence s_accept;
        $rose(hs_busy) && gap >= 12'h898;
    endsequence
    sequence s_go_start;
        ##[0:40] !txd;
    endsequence
    AST_GO_AHEAD: assert property (s_accept |-> s_go_start)
        else $error("no start bit after announce accepted");
    AST_END_LF: assert property (cmd_end |-> cmd_valid && cmd_data == 8'h0A)
        else $error("end flag without line feed");
    AST_END_DROPS_BUSY: assert property (cmd_end |-> ##[1:2] !hs_busy)
        else $error("busy held after terminator");
    AST_TEXT_IN_CMD: assert property (cmd_valid |-> hs_busy || $past(hs_busy))
        else $error("command byte outside a command");
    AST_VALID_PULSE: assert property (cmd_valid |=> !cmd_valid)
        else $error("command valid longer than one cycle");
    AST_RSP_PULSE: assert property (rsp_ready |=> !rsp_ready)
        else $error("response ready longer than one cycle");
    AST_RSP_START: assert property (rsp_ready |-> ##[1:16] !txd)
        else $error("response start bit late");
    AST_RSP_SPACING: assert property (rsp_ready |-> gap >= 12'h7D0)
        else $error("responses closer than a frame");
    AST_IDLE_HIGH: assert property ($rose(nrst) |-> txd [*8])
        else $error("line not idle after reset");
endmodule // rsh_port_asserts
bind rsh_port rsh_port_asserts u_chk (.clk(clk), .nrst(nrst), .txd(txd),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_end(cmd_end),
    .hs_busy(hs_busy), .rsp_ready(rsp_ready));

// ### tb/test_rsh_port.sv
// self-checking bench for the serial handshake port
`timescale 1ns/1ns
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch at %0t: %s", $time, m); end end
module test_rsh_port;
    logic clk = 1'b0, nrst = 1'b0, cmd_ready = 1'b1, rsp_valid = 1'b0;
    logic [16:0] baud_sel = 17'h1C200;
    logic [7:0] rsp_data = 8'h00, b;
    logic rxd, txd, cmd_valid, cmd_end, hs_busy, frame_err, rsp_ready, ok;
    logic [7:0] cmd_data;
    logic [8:0] q[$];
    integer n_fail = 0, n_checks = 0, n_low = 0, i;
    always #20 clk = ~clk;
    rsh_host host (.clk(clk), .rxd(rxd), .txd(txd));
    rsh_port dut (.clk(clk), .nrst(nrst), .rxd(rxd), .txd(txd), .baud_sel(baud_sel),
        .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
        .cmd_end(cmd_end), .hs_busy(hs_busy), .frame_err(frame_err),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));
    always @(posedge clk)
    begin
        if (cmd_valid === 1'b1)
            q.push_back({cmd_end, cmd_data});
        // txd is unknown until the first reset edge, so only count once out of reset
        if (nrst === 1'b1 && txd !== 1'b1)
            n_low++;
    end
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task wait_ready;
        begin
            // step past the current edge first so a pulse already seen is not taken twice
            @(posedge clk);
            for (i = 1; i < 3000 && rsp_ready !== 1'b1; i++)
                @(posedge clk);
            if (rsp_ready !== 1'b1)
            begin
                n_fail++;
                $display("mismatch at %0t: response never taken", $time);
                end_sim;
            end
        end
    endtask
    task t_refuse;
        begin
            host.send(8'h41, 1'b1);
            @(posedge clk) cmd_ready <= 1'b0;
            host.send(8'hAA, 1'b1);
            `CHK(n_low, 0, "refused byte answered")
            `CHK(hs_busy, 1'b0, "busy after refused byte")
            `CHK(q.size(), 0, "refused byte forwarded")
            @(posedge clk) cmd_ready <= 1'b1;
        end
    endtask
    task t_frame;
        begin
            host.send(8'hAA, 1'b0);
            `CHK(frame_err, 1'b1, "low stop not flagged")
            `CHK(n_low, 0, "bad frame answered")
        end
    endtask
    task t_command;
        begin
            fork
                host.send(8'hAA, 1'b1);
                host.recv(b, ok);
            join
            `CHK({ok, b}, 9'h1CC, "go-ahead byte wrong")
            `CHK(hs_busy, 1'b1, "busy low after go-ahead")
            host.send(8'h53, 1'b1);
            host.send(8'h3F, 1'b1);
            host.send(8'h0A, 1'b1);
            `CHK(q.size(), 3, "command byte count")
            `CHK({q[0], q[1], q[2]}, 27'h14C7F0A, "command bytes")
            `CHK(hs_busy, 1'b0, "busy after terminator")
            `CHK(frame_err, 1'b0, "good frame kept error")
        end
    endtask
    task t_response;
        begin
            // a rate above the top one must still run the link at the top rate
            @(posedge clk) baud_sel <= 17'h1FFFF;
            rsp_data <= 8'h5A;
            rsp_valid <= 1'b1;
            wait_ready;
            // valid stays up so the second byte is taken at the next idle
            rsp_data <= 8'h81;
            fork
                begin
                    host.recv(b, ok);
                    `CHK({ok, b}, 9'h15A, "first response")
                    host.recv(b, ok);
                end
                begin
                    wait_ready;
                    rsp_valid <= 1'b0;
                end
            join
            `CHK({ok, b}, 9'h181, "back-to-back response")
        end
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_refuse;
        t_frame;
        t_command;
        t_response;
        end_sim;
    end
endmodule // test_rsh_port
